// ---- src/csso_pkg.sv ----
// Package with register map, field layouts, reset values and carriers for the clock status/sync/output block.
package csso_pkg;

  // Register offsets on the configuration port.
  localparam logic [7:0] CSSO_ADDR_INPUT_CFG   = 8'h95;
  localparam logic [7:0] CSSO_ADDR_SYSREF_CFG  = 8'h96;
  localparam logic [7:0] CSSO_ADDR_STATUS      = 8'h97;
  localparam logic [7:0] CSSO_ADDR_RELOCK      = 8'h98;
  localparam logic [7:0] CSSO_ADDR_DIV_SYNC    = 8'h99;
  localparam logic [7:0] CSSO_ADDR_SYSREF_GO   = 8'h9B;
  localparam logic [7:0] CSSO_ADDR_OE_LOW      = 8'h9C;
  localparam logic [7:0] CSSO_ADDR_OE_MID      = 8'h9D;
  localparam logic [7:0] CSSO_ADDR_OE_HIGH     = 8'h9E;
  localparam logic [7:0] CSSO_ADDR_OE_SPARE    = 8'h9F;

  // Command bit position shared by the three self-clearing command registers.
  localparam int CSSO_CMD_BIT = 7;

  // Input configuration register fields.
  localparam int CSSO_SEL_LSB      = 0;
  localparam int CSSO_FORCE_VC_BIT = 2;
  localparam int CSSO_EXT_C_BIT    = 3;
  localparam int CSSO_EXT_D_BIT    = 4;

  // Sysref configuration register fields.
  localparam int CSSO_GEN_MODE_LSB = 0;
  localparam int CSSO_OUT_SET_LSB  = 4;

  // Status register fields.
  localparam int CSSO_ST_PRESENT_BIT = 0;
  localparam int CSSO_ST_FORCED_BIT  = 1;
  localparam int CSSO_ST_ACTIVE_LSB  = 2;
  localparam int CSSO_ST_READY_BIT   = 4;

  // High output enable register: only bits 2:1 are implemented.
  localparam int CSSO_OE_HIGH_LSB = 1;

  // Reset values.
  localparam logic [7:0] CSSO_OE_RESET       = 8'h00;
  localparam logic [7:0] CSSO_CFG_RESET      = 8'h00;
  localparam logic [2:0] CSSO_GEN_MODE_RESET = 3'h0;
  localparam logic [1:0] CSSO_OUT_SET_RESET  = 2'h0;

  // Generator mode encodings.
  localparam logic [2:0] CSSO_GEN_MODE_CONT   = 3'h4;
  localparam logic [2:0] CSSO_GEN_MODE_REPEAT = 3'h5;
  localparam logic [2:0] CSSO_GEN_MODE_STOP   = 3'h7;

  // Number of output enables.
  localparam int CSSO_NUM_OUT = 18;

  // Register port request.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csso_req_t;

  // Command pulses toward the clock core.
  typedef struct packed {
    logic relock;
    logic div_sync;
    logic sysref_go;
  } csso_cmd_t;

  // Raw status levels from the clock core.
  typedef struct packed {
    logic       ref_present;
    logic       vc_forced_pin;
    logic [1:0] active_input;
  } csso_status_t;

endpackage : csso_pkg

// ---- src/csso_sync3.sv ----
// Three-stage synchroniser that accepts a change once the second and third stages agree.
`timescale 1ns/10ps
`default_nettype none
module csso_sync3 #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Asynchronous input and filtered output.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // Refuse a width the logic cannot serve.
  if (WIDTH < 1) begin : g_bad_width
    $error("csso_sync3 needs WIDTH of at least one");
  end

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] held;
  } csso_sync_state_t;

  csso_sync_state_t st_ff;
  csso_sync_state_t nxt_st;

  // The first stage feeds only the second; only agreeing later stages update the held value.
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = async_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.held[i] = st_ff.s3[i];
      end
    end
  end

  // Synchronous active-low reset clears all stages.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync_out = st_ff.held;

endmodule : csso_sync3
`default_nettype wire

// ---- src/csso_regs.sv ----
// Register slice for reference status, synchronisation commands and output enables.
`timescale 1ns/10ps
`default_nettype none
module csso_regs
  import csso_pkg::*;
(
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Configuration port.
  input  wire csso_req_t               req,
  output logic      [7:0]              rd_data,
  output logic                         rd_valid,
  // Status from the clock core, asynchronous to clk.
  input  wire csso_status_t            core_status,
  // Sysref generator state from the core: level that rises when generator initialised.
  input  wire logic                    sysref_init_done,
  // Controls toward the clock core.
  output logic      [1:0]              input_select,
  output logic                         force_vc,
  output logic      [2:0]              sysref_generator_mode,
  output logic      [1:0]              sysref_output_setting,
  output logic                         sysref_stop,
  output var csso_cmd_t                cmd,
  // Output drivers: enable and idle level per output.
  output logic      [CSSO_NUM_OUT-1:0] out_enable,
  output logic      [CSSO_NUM_OUT-1:0] out_idle_high
);

  // Whole state of the slice outside the status synchroniser in one record, command pulses and the read answer included.
  typedef struct packed {
    logic [7:0] oe_low;
    logic [7:0] oe_mid;
    logic [1:0] oe_high;
    logic [7:0] input_cfg;
    logic [2:0] gen_mode;
    logic [1:0] out_set;
    logic       ready;
    logic       stop;
    csso_cmd_t  cmd;
    logic [7:0] rdata;
    logic       rvalid;
    logic       init_d;
  } csso_state_t;

  // State record, its next value and the combinational helpers around it.
  csso_state_t  st_ff;
  csso_state_t  nxt_st;
  csso_status_t status_sync;
  logic         init_sync;
  logic         vc_forced;
  logic [7:0]   status_word;

  // The three enable registers hold eight, eight and two bits; another count would leave outputs unmapped.
  if (CSSO_NUM_OUT != 8 + 8 + 2) begin : g_bad_outputs
    $error("csso_regs serves exactly eighteen output enables");
  end

  // The forced, active and ready status fields must fit in the single status byte that the read mux returns.
  if ((CSSO_ST_READY_BIT > 7) || (CSSO_ST_ACTIVE_LSB > 6) || (CSSO_ST_FORCED_BIT > 7)) begin : g_bad_status
    $error("csso_regs status fields overflow the status byte");
  end

  // The two implemented bits of the high enable register must sit inside its byte.
  if (CSSO_OE_HIGH_LSB > 6) begin : g_bad_oe_high
    $error("csso_regs high enable field lies outside its byte");
  end

  // A write strobe to one address; shared by the command and stop decoders.
  function automatic logic wr_hit(input csso_req_t r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction : wr_hit

  // Command writes decode to a single predicate used three times.
  function automatic logic cmd_hit(input csso_req_t r, input logic [7:0] a);
    return wr_hit(r, a) && r.wdata[CSSO_CMD_BIT];
  endfunction : cmd_hit

  // Core status levels come from another clock, so they pass the filtering synchroniser.
  // The cost is a few cycles of latency on every status bit, which software never notices;
  // the gain is that a glitch of a single cycle on a core line never reaches the status byte.
  csso_sync3 #(
    .WIDTH (5)
  ) u_status_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({core_status, sysref_init_done}),
    .sync_out ({status_sync, init_sync})
  );

  // Forced control voltage is reported for either the register or the pin source.
  assign vc_forced = st_ff.input_cfg[CSSO_FORCE_VC_BIT] | status_sync.vc_forced_pin;

  // Status word assembled from live core state, not from the requested selection.
  always_comb begin
    status_word                                       = 8'h00;
    status_word[CSSO_ST_PRESENT_BIT]                  = status_sync.ref_present;
    status_word[CSSO_ST_FORCED_BIT]                   = vc_forced;
    status_word[CSSO_ST_ACTIVE_LSB +: 2]              = status_sync.active_input;
    status_word[CSSO_ST_READY_BIT]                    = st_ff.ready;
  end

  // Next-state logic for all registers, command pulses and read data.
  // A read and a write in the same cycle both act; the read returns the value held before the write,
  // because the read mux looks at st_ff, so software that wants the new value reads once more.
  // Command pulses are rebuilt from zero every cycle, so none can stick high; a strobe held up for
  // several cycles does give one pulse per cycle, which is why the port takes one-cycle strobes only.
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.cmd    = '0;
    nxt_st.stop   = 1'b0;
    nxt_st.rvalid = 1'b0;
    nxt_st.init_d = init_sync; // Previous synchronised init level, kept for edge detection.

    // Writes to configuration and enable registers.
    if (req.wr) begin
      case (req.addr)
        CSSO_ADDR_INPUT_CFG: begin
          nxt_st.input_cfg = req.wdata & 8'h1F;
        end
        CSSO_ADDR_SYSREF_CFG: begin
          // Only the mode and output-setting fields are stored; the other bits are dropped.
          nxt_st.gen_mode = req.wdata[CSSO_GEN_MODE_LSB +: 3];
          nxt_st.out_set  = req.wdata[CSSO_OUT_SET_LSB +: 2];
        end
        CSSO_ADDR_OE_LOW: begin
          nxt_st.oe_low = req.wdata;
        end
        CSSO_ADDR_OE_MID: begin
          nxt_st.oe_mid = req.wdata;
        end
        CSSO_ADDR_OE_HIGH: begin
          nxt_st.oe_high = req.wdata[CSSO_OE_HIGH_LSB +: 2];
        end
        default: begin
          // Status, spare, command and unmapped locations leave every stored register alone.
          nxt_st.oe_high = st_ff.oe_high;
        end
      endcase
    end

    // Self-clearing commands: one pulse per write of 1, repeatable.
    nxt_st.cmd.relock    = cmd_hit(req, CSSO_ADDR_RELOCK);
    nxt_st.cmd.div_sync  = cmd_hit(req, CSSO_ADDR_DIV_SYNC);
    nxt_st.cmd.sysref_go = cmd_hit(req, CSSO_ADDR_SYSREF_GO);

    // Writing the stop code ends continuous generation and drops the ready flag.
    // The clear comes before the set below, so an init edge in the same cycle leaves ready at 1.
    if (wr_hit(req, CSSO_ADDR_SYSREF_CFG) && (req.wdata[CSSO_GEN_MODE_LSB +: 3] == CSSO_GEN_MODE_STOP)) begin
      nxt_st.stop  = 1'b1;
      nxt_st.ready = 1'b0;
    end

    // Ready sets on core initialisation in a periodic mode; set wins over the stop clear.
    // Only the rising edge of the synchronised level counts, so a level the core leaves high
    // cannot set ready again after software has stopped the generator.
    if (init_sync && !st_ff.init_d &&
        ((st_ff.gen_mode == CSSO_GEN_MODE_CONT) || (st_ff.gen_mode == CSSO_GEN_MODE_REPEAT))) begin
      nxt_st.ready = 1'b1;
    end

    // Reads answer one cycle later from a register; command and spare locations read zero.
    if (req.rd) begin
      nxt_st.rvalid = 1'b1;
      case (req.addr)
        CSSO_ADDR_INPUT_CFG:  nxt_st.rdata = st_ff.input_cfg;
        CSSO_ADDR_SYSREF_CFG: nxt_st.rdata = {2'h0, st_ff.out_set, 1'b0, st_ff.gen_mode};
        CSSO_ADDR_STATUS:     nxt_st.rdata = status_word;
        CSSO_ADDR_OE_LOW:     nxt_st.rdata = st_ff.oe_low;
        CSSO_ADDR_OE_MID:     nxt_st.rdata = st_ff.oe_mid;
        CSSO_ADDR_OE_HIGH:    nxt_st.rdata = {5'h00, st_ff.oe_high, 1'b0};
        default:              nxt_st.rdata = 8'h00;
      endcase
    end
  end

  // State register; synchronous reset leaves every output disabled.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff           <= '0;
      st_ff.oe_low    <= CSSO_OE_RESET;
      st_ff.oe_mid    <= CSSO_OE_RESET;
      st_ff.input_cfg <= CSSO_CFG_RESET;
      st_ff.gen_mode  <= CSSO_GEN_MODE_RESET;
      st_ff.out_set   <= CSSO_OUT_SET_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Register-driven outputs.
  assign rd_data               = st_ff.rdata;
  assign rd_valid              = st_ff.rvalid;
  assign input_select          = st_ff.input_cfg[CSSO_SEL_LSB +: 2];
  assign force_vc              = st_ff.input_cfg[CSSO_FORCE_VC_BIT];
  assign sysref_generator_mode = st_ff.gen_mode;
  assign sysref_output_setting = st_ff.out_set;
  assign sysref_stop           = st_ff.stop;
  assign cmd                   = st_ff.cmd;

  // Enables are plain levels; the output stage gates them without regard to its own clock.
  assign out_enable = {st_ff.oe_high, st_ff.oe_mid, st_ff.oe_low};

  // Idle level: low everywhere except C and D outputs fed from the external oscillator.
  // The output stage applies this level only while the matching enable is 0, so a disabled
  // C or D output rests high and the receiver sees no extra edge when it is switched off.
  always_comb begin
    out_idle_high      = '0;
    out_idle_high[5:4] = {2{st_ff.input_cfg[CSSO_EXT_C_BIT]}};
    out_idle_high[7:6] = {2{st_ff.input_cfg[CSSO_EXT_D_BIT]}};
  end

endmodule : csso_regs
`default_nettype wire

// ---- verif/csso_regs_asserts.sv ----
// Port-level checks for the register slice, bound to every instance.
`timescale 1ns/10ps
`default_nettype none
module csso_regs_asserts
  import csso_pkg::*;
(
  // Clock and reset.
  input wire logic                    clk,
  input wire logic                    rst_n,
  // Register port.
  input wire csso_req_t               req,
  input wire logic [7:0]              rd_data,
  input wire logic                    rd_valid,
  // Controls toward the core.
  input wire logic                    sysref_stop,
  input wire csso_cmd_t               cmd,
  input wire logic [CSSO_NUM_OUT-1:0] out_enable,
  input wire logic [CSSO_NUM_OUT-1:0] out_idle_high
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A write strobe to one address; the command and stop properties add their own data qualifier.
  sequence s_wr(logic [7:0] a);
    req.wr && req.addr == a;
  endsequence
  property p_relock; s_wr(CSSO_ADDR_RELOCK) ##0 req.wdata[7] |=> cmd.relock; endproperty
  property p_src;
    cmd.relock |-> $past(req.wr) && $past(req.addr) == CSSO_ADDR_RELOCK && $past(req.wdata[7]);
  endproperty
  property p_sync; s_wr(CSSO_ADDR_DIV_SYNC) ##0 req.wdata[7] |=> cmd.div_sync; endproperty
  property p_go; s_wr(CSSO_ADDR_SYSREF_GO) ##0 req.wdata[7] |=> cmd.sysref_go; endproperty
  property p_stop; s_wr(CSSO_ADDR_SYSREF_CFG) ##0 req.wdata[2:0] == CSSO_GEN_MODE_STOP |=> sysref_stop; endproperty
  property p_oe_rst; $rose(rst_n) |-> out_enable == '0 && out_idle_high == '0; endproperty
  property p_oe_map; s_wr(CSSO_ADDR_OE_LOW) |=> out_enable[7:0] == $past(req.wdata); endproperty
  property p_idle;
    s_wr(CSSO_ADDR_INPUT_CFG) |=> out_idle_high[7:4] == {{2{$past(req.wdata[4])}}, {2{$past(req.wdata[3])}}};
  endproperty
  property p_wo; req.rd && req.addr == CSSO_ADDR_RELOCK |=> rd_valid && rd_data == 8'h00; endproperty
  a_relock: assert property (p_relock) else $error("relock pulse missing");
  a_src: assert property (p_src) else $error("relock pulse without write");
  a_sync: assert property (p_sync) else $error("divider sync pulse missing");
  a_go: assert property (p_go) else $error("sysref start pulse missing");
  a_stop: assert property (p_stop) else $error("sysref stop pulse missing");
  a_oe_rst: assert property (p_oe_rst) else $error("enables not cleared by reset");
  a_oe_map: assert property (p_oe_map) else $error("low enable byte mismatch");
  a_idle: assert property (p_idle) else $error("idle level of C or D wrong");
  a_wo: assert property (p_wo) else $error("write-only register read not zero");
endmodule : csso_regs_asserts
bind csso_regs csso_regs_asserts u_csso_regs_asserts (.clk(clk), .rst_n(rst_n), .req(req), .rd_data(rd_data),
  .rd_valid(rd_valid), .sysref_stop(sysref_stop), .cmd(cmd), .out_enable(out_enable),
  .out_idle_high(out_idle_high));
`default_nettype wire

// ---- verif/csso_regs_test.sv ----
// Self-checking bench for the register slice with a reference model in the bench.
`timescale 1ns/10ps
`default_nettype none
module csso_regs_test;
  import csso_pkg::*;
  logic                    clk, rst_n, sysref_init_done, rd_valid, sysref_stop, force_vc;
  logic [7:0]              rd_data, oe0, oe1, oe2, cfg, a;
  logic [1:0]              input_select, sysref_output_setting;
  logic [2:0]              sysref_generator_mode;
  logic [CSSO_NUM_OUT-1:0] out_enable, out_idle_high;
  csso_req_t               req;
  csso_status_t            core_status;
  csso_cmd_t               cmd;
  int                      error_cnt = 0;
  int                      total_checks = 0;
  int                      npl[3] = '{0, 0, 0};
  int                      nstop = 0;
  csso_regs u_csso_regs (.clk(clk), .rst_n(rst_n), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
    .core_status(core_status), .sysref_init_done(sysref_init_done), .input_select(input_select),
    .force_vc(force_vc), .sysref_generator_mode(sysref_generator_mode),
    .sysref_output_setting(sysref_output_setting), .sysref_stop(sysref_stop), .cmd(cmd),
    .out_enable(out_enable), .out_idle_high(out_idle_high));
  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Pulse counters: a pulse that sticks high counts every cycle and is caught.
  always @(posedge clk) begin
    npl[0] <= npl[0] + int'(cmd.div_sync);
    npl[1] <= npl[1] + int'(cmd.relock);
    npl[2] <= npl[2] + int'(cmd.sysref_go);
    nstop <= nstop + int'(sysref_stop);
  end
  task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] seen);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    req.wr <= 1'b1;
    req.addr <= ad;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  // Reads are checked together with their valid flag, one cycle after the strobe.
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= ad;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk("read", {9'h0, 1'b1, exp}, {9'h0, rd_valid, rd_data});
  endtask : rd
  // Status byte as the model expects it from the last inputs and settings.
  function automatic logic [7:0] st(input logic rdy);
    return {3'h0, rdy, core_status.active_input, core_status.vc_forced_pin | cfg[2], core_status.ref_present};
  endfunction : st
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // Watchdog sized well beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end
  initial begin
    req = '0;
    core_status = '0;
    sysref_init_done = 1'b0;
    rst_n = 1'b0;
    cfg = 8'h00;
    void'($urandom(32'hB5406792));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(CSSO_ADDR_OE_LOW, 8'h00);
    rd(CSSO_ADDR_OE_MID, 8'h00);
    chk("out_enable", '0, out_enable);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      oe0 = 8'($urandom);
      oe1 = 8'($urandom);
      oe2 = 8'($urandom);
      wr(CSSO_ADDR_OE_LOW, oe0);
      wr(CSSO_ADDR_OE_MID, oe1);
      wr(CSSO_ADDR_OE_HIGH, oe2);
      wr(CSSO_ADDR_OE_SPARE, 8'hFF);
      rd(CSSO_ADDR_OE_LOW, oe0);
      rd(CSSO_ADDR_OE_HIGH, oe2 & 8'h06);
      rd(CSSO_ADDR_OE_SPARE, 8'h00);
      chk("out_enable", {oe2[2:1], oe1, oe0}, out_enable);
    end
    rd(8'hA0, 8'h00);
    $display("test enables done");
    // Divider sync goes first, as software is expected to order it.
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? CSSO_ADDR_DIV_SYNC : (i == 1) ? CSSO_ADDR_RELOCK : CSSO_ADDR_SYSREF_GO;
      wr(a, 8'h80);
      wr(a, 8'h80);
      wr(a, 8'h7F);
      rd(a, 8'h00);
      chk("pulses", 18'h2, 18'(npl[i]));
    end
    $display("test commands done");
    for (int i = 0; i < 6; i++) begin
      cfg = 8'($urandom) & 8'h1F;
      wr(CSSO_ADDR_INPUT_CFG, cfg);
      core_status <= 4'($urandom);
      repeat (8) @(posedge clk);
      rd(CSSO_ADDR_STATUS, st(1'b0));
      chk("input_select", {16'h0, cfg[1:0]}, {16'h0, input_select});
      chk("idle", {10'h0, cfg[4], cfg[4], cfg[3], cfg[3], 4'h0}, out_idle_high);
      rd(CSSO_ADDR_INPUT_CFG, cfg);
      chk("force_vc", {17'h0, cfg[2]}, {17'h0, force_vc});
    end
    $display("test status done");
    for (int i = 0; i < 2; i++) begin
      a = {2'h0, 2'($urandom), 1'b0, (i == 1) ? CSSO_GEN_MODE_REPEAT : CSSO_GEN_MODE_CONT};
      wr(CSSO_ADDR_SYSREF_CFG, a);
      rd(CSSO_ADDR_SYSREF_CFG, a);
      chk("generator mode", {15'h0, a[2:0]}, {15'h0, sysref_generator_mode});
      chk("output setting", {16'h0, a[5:4]}, {16'h0, sysref_output_setting});
      rd(CSSO_ADDR_STATUS, st(1'b0));
      @(posedge clk);
      sysref_init_done <= 1'b1;
      repeat (8) @(posedge clk);
      rd(CSSO_ADDR_STATUS, st(1'b1));
      wr(CSSO_ADDR_SYSREF_CFG, {5'h0, CSSO_GEN_MODE_STOP});
      sysref_init_done <= 1'b0;
      rd(CSSO_ADDR_STATUS, st(1'b0));
      chk("generator mode", {15'h0, CSSO_GEN_MODE_STOP}, {15'h0, sysref_generator_mode});
      chk("stop pulses", 18'(i + 1), 18'(nstop));
    end
    $display("test sysref done");
    // A reset in mid-run must drop every enable again.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("out_enable", '0, out_enable);
    chk("idle", '0, out_idle_high);
    $display("test second reset done");
    conclude();
  end
endmodule : csso_regs_test
`default_nettype wire
